//--- core/dcc_cfg.svh
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// Register indices; byte address is four times the index
`define DCC_IDX_INTCTL   8'h0b
`define DCC_IDX_PFLAG    8'h0c
`define DCC_IDX_CMPCTL   8'h1f
`define DCC_IDX_PORTA    8'h05
`define DCC_IDX_PADIR    8'h85
`define DCC_IDX_PENA     8'h8c
`define DCC_IDX_VREF     8'h9f

// Field positions
`define DCC_B_RES2       7
`define DCC_B_RES1       6
`define DCC_B_SWITCH     3
`define DCC_B_CHG        6
`define DCC_B_GLOBAL_EN  7
`define DCC_B_PERIPH_EN  6

// Reset values and the VREF write mask
`define DCC_RST_INTCTL   8'h00
`define DCC_RST_MODE     3'h0
`define DCC_RST_PADIR    5'h1f
`define DCC_RST_VREF     8'h00
`define DCC_RST_PORTA    5'h00
`define DCC_VREF_MASK    8'hef

// Analog pin masks (pins 3..0) per mode
`define DCC_AM_M0        4'hf
`define DCC_AM_M1        4'hf
`define DCC_AM_M2        4'hf
`define DCC_AM_M3        4'h7
`define DCC_AM_M4        4'hf
`define DCC_AM_M5        4'h6
`define DCC_AM_M6        4'h7
`define DCC_AM_M7        4'h0

`endif

//--- core/dcc_pkg.sv
package dcc_pkg;

    // Comparator routing modes
    typedef enum logic [2:0] {
        DCC_M_RESET  = 3'h0,
        DCC_M_ONE    = 3'h1,
        DCC_M_FOUR   = 3'h2,
        DCC_M_COMREF = 3'h3,
        DCC_M_INDEP  = 3'h4,
        DCC_M_SPLIT  = 3'h5,
        DCC_M_OUTPUT = 3'h6,
        DCC_M_OFF    = 3'h7
    } dcc_mode_t;

    // Bus slave data-phase states
    typedef enum logic [3:0] {
        DCC_ST_IDLE  = 4'b0001,
        DCC_ST_WRITE = 4'b0010,
        DCC_ST_READ  = 4'b0100,
        DCC_ST_RDONE = 4'b1000
    } dcc_bus_st_t;

endpackage

//--- core/dcc_top.sv
// The AHB-Lite register port was left to the implementer.
`include "dcc_cfg.svh"

module dcc_top
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Analog comparator results and control
    input  wire logic        cmp1_raw,
    input  wire logic        cmp2_raw,
    output logic             cmp_power_on,
    output logic      [1:0]  cmp1_inv_sel,
    output logic      [1:0]  cmp2_inv_sel,
    output logic             vref_to_noninv,
    // Voltage reference control
    output logic             vref_enable,
    output logic             vref_pin_out,
    output logic             vref_low_range,
    output logic      [3:0]  vref_level,
    // Port A pins
    input  wire logic [4:0]  port_a_in,
    output logic      [4:0]  port_a_out,
    output logic      [4:0]  port_a_oe,
    output logic      [3:0]  port_a_analog,
    // Sleep and interrupt
    input  wire logic        sleep,
    output logic             cpu_irq,
    output logic             wake
);

    dcc_mode_t   mode_q;
    dcc_bus_st_t st_q;
    logic        switch_q;
    logic [1:0]  res_q;
    logic [1:0]  latch_q;
    logic        flag_q;
    logic        chg_en_q;
    logic [7:0]  intctl_q;
    logic [4:0]  dir_q;
    logic [7:0]  vref_q;
    logic [4:0]  pdata_q;
    logic [7:0]  idx_q;
    logic        hit_q;
    logic [31:0] hrdata_q;
    logic [7:0]  rd_mux;
    logic        addr_ok;
    logic        take;
    logic        wr_now;
    logic        mismatch;
    logic        cmp_access;
    logic [3:0]  amask;

    // Address phase decode
    assign take    = hsel & htrans[1] & hready;
    assign addr_ok = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
    assign wr_now  = (st_q == DCC_ST_WRITE) & hit_q;

    // Bus state: reads take one wait state
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= DCC_ST_IDLE;
        end else begin
            unique case (st_q)
                DCC_ST_READ: begin
                    st_q <= DCC_ST_RDONE;
                end
                default: begin
                    if (take & hwrite) begin
                        st_q <= DCC_ST_WRITE;
                    end else if (take) begin
                        st_q <= DCC_ST_READ;
                    end else begin
                        st_q <= DCC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Latched address of the pending transfer
    always_ff @(posedge clk) begin
        if (reset) begin
            idx_q <= 8'h00;
            hit_q <= 1'b0;
        end else if (take) begin
            idx_q <= haddr[9:2];
            hit_q <= addr_ok;
        end
    end

    assign hreadyout = (st_q != DCC_ST_READ);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Analog pin mask per mode
    always_comb begin
        unique case (mode_q)
            DCC_M_RESET:  amask = `DCC_AM_M0;
            DCC_M_ONE:    amask = `DCC_AM_M1;
            DCC_M_FOUR:   amask = `DCC_AM_M2;
            DCC_M_COMREF: amask = `DCC_AM_M3;
            DCC_M_INDEP:  amask = `DCC_AM_M4;
            DCC_M_SPLIT:  amask = `DCC_AM_M5;
            DCC_M_OUTPUT: amask = `DCC_AM_M6;
            DCC_M_OFF:    amask = `DCC_AM_M7;
        endcase
    end
    assign port_a_analog = amask;

    // Read multiplexer
    always_comb begin
        rd_mux = 8'h00;
        if (hit_q) begin
            unique case (idx_q)
                `DCC_IDX_CMPCTL: begin
                    rd_mux = {res_q, 2'b00, switch_q, mode_q};
                end
                `DCC_IDX_PFLAG: begin
                    rd_mux[`DCC_B_CHG] = flag_q;
                end
                `DCC_IDX_PENA: begin
                    rd_mux[`DCC_B_CHG] = chg_en_q;
                end
                `DCC_IDX_INTCTL: rd_mux = intctl_q;
                `DCC_IDX_PADIR:  rd_mux = {3'b000, dir_q};
                `DCC_IDX_VREF:   rd_mux = vref_q;
                `DCC_IDX_PORTA: begin
                    rd_mux = {3'b000, port_a_in & ~{1'b0, amask}};
                end
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // Read data captured in the wait state
    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata_q <= 32'h0;
        end else if (st_q == DCC_ST_READ) begin
            hrdata_q <= {24'h0, rd_mux};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q   <= dcc_mode_t'(`DCC_RST_MODE);
            switch_q <= 1'b0;
        end else if (wr_now && idx_q == `DCC_IDX_CMPCTL) begin
            mode_q   <= dcc_mode_t'(hwdata[2:0]);
            switch_q <= hwdata[`DCC_B_SWITCH];
        end
    end

    // Plain software registers
    always_ff @(posedge clk) begin
        if (reset) begin
            intctl_q <= `DCC_RST_INTCTL;
            dir_q    <= `DCC_RST_PADIR;
            vref_q   <= `DCC_RST_VREF;
            pdata_q  <= `DCC_RST_PORTA;
            chg_en_q <= 1'b0;
        end else if (wr_now) begin
            unique case (idx_q)
                `DCC_IDX_INTCTL: intctl_q <= hwdata[7:0];
                `DCC_IDX_PADIR:  dir_q <= hwdata[4:0];
                `DCC_IDX_VREF:   vref_q <= hwdata[7:0] & `DCC_VREF_MASK;
                `DCC_IDX_PORTA:  pdata_q <= hwdata[4:0];
                `DCC_IDX_PENA:   chg_en_q <= hwdata[`DCC_B_CHG];
                default: ;
            endcase
        end
    end

    assign cmp_power_on = ~reset & (mode_q != DCC_M_OFF);

    // Result bits sampled, zero while unpowered
    always_ff @(posedge clk) begin
        if (reset) begin
            res_q <= 2'b00;
        end else if (cmp_power_on) begin
            res_q <= {cmp2_raw, cmp1_raw};
        end else begin
            res_q <= 2'b00;
        end
    end

    assign cmp_access = hit_q & (idx_q == `DCC_IDX_CMPCTL)
                        & ((st_q == DCC_ST_READ) | wr_now);

    always_ff @(posedge clk) begin
        if (reset) begin
            latch_q <= 2'b00;
        end else if (cmp_access) begin
            latch_q <= res_q;
        end
    end

    assign mismatch = (res_q != latch_q);

    // read race not modelled, set wins
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else if (mismatch) begin
            flag_q <= 1'b1;
        end else if (wr_now && idx_q == `DCC_IDX_PFLAG) begin
            flag_q <= hwdata[`DCC_B_CHG];
        end
    end

    assign cpu_irq = flag_q & chg_en_q & intctl_q[`DCC_B_PERIPH_EN]
                     & intctl_q[`DCC_B_GLOBAL_EN];
    assign wake = sleep & flag_q & chg_en_q;

    // Input routing
    always_comb begin
        cmp1_inv_sel   = 2'd0;
        cmp2_inv_sel   = 2'd1;
        vref_to_noninv = 1'b0;
        unique case (mode_q)
            DCC_M_ONE: begin
                cmp1_inv_sel = switch_q ? 2'd3 : 2'd0;
            end
            DCC_M_FOUR: begin
                cmp1_inv_sel   = switch_q ? 2'd3 : 2'd0;
                cmp2_inv_sel   = switch_q ? 2'd2 : 2'd1;
                vref_to_noninv = 1'b1;
            end
            default: ;
        endcase
    end

    // Voltage reference control fields
    assign vref_enable    = vref_q[7];
    assign vref_pin_out   = vref_q[6];
    assign vref_low_range = vref_q[5];
    assign vref_level     = vref_q[3:0];

    always_comb begin
        port_a_out = pdata_q;
        if (mode_q == DCC_M_OUTPUT) begin
            port_a_out[3] = cmp1_raw & cmp_power_on;
            port_a_out[4] = cmp2_raw & cmp_power_on;
        end
        port_a_oe = ~dir_q;
    end

    default clocking dcc_cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_result_read: assert property (
        st_q == DCC_ST_READ && hit_q && idx_q == `DCC_IDX_CMPCTL
        |=> hrdata_q[7:6] == $past(res_q) && hrdata_q[5:4] == 2'b00)
        else $error("result bits wrong on read");

    a_vref_mode: assert property (
        vref_to_noninv == (mode_q == DCC_M_FOUR))
        else $error("reference routing wrong");

    a_switch_route: assert property (
        mode_q == DCC_M_ONE && switch_q |-> cmp1_inv_sel == 2'd3)
        else $error("switch routing wrong");

    a_out_mux: assert property (
        mode_q == DCC_M_OUTPUT |-> port_a_out[4:3] == {cmp2_raw, cmp1_raw})
        else $error("output mux wrong");

    a_dir_gate: assert property (
        dir_q[3] |-> !port_a_oe[3])
        else $error("pin driven while input");

    a_flag_set: assert property (
        mismatch |=> flag_q)
        else $error("flag missed mismatch");

    a_access_end: assert property (
        cmp_access ##1 $stable(res_q) |-> !mismatch)
        else $error("access did not end mismatch");

    a_irq_gate: assert property (
        $rose(cpu_irq) |-> flag_q && intctl_q[`DCC_B_GLOBAL_EN])
        else $error("interrupt without enables");

    a_power_off: assert property (
        mode_q == DCC_M_OFF |-> !cmp_power_on ##1 res_q == 2'b00)
        else $error("comparators not off");

    a_read_wait: assert property (
        st_q == DCC_ST_READ |-> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");

    a_reset_state: assert property (
        $fell(reset) |-> mode_q == DCC_M_RESET && !flag_q
                         && dir_q == `DCC_RST_PADIR)
        else $error("state after reset wrong");

    a_flag_write: assert property (
        wr_now && idx_q == `DCC_IDX_PFLAG && !mismatch
        |=> flag_q == $past(hwdata[`DCC_B_CHG]))
        else $error("flag write not applied");

    a_irq_enable: assert property (
        flag_q && chg_en_q && intctl_q[`DCC_B_PERIPH_EN]
        && intctl_q[`DCC_B_GLOBAL_EN] |-> cpu_irq)
        else $error("enabled interrupt missing");

    a_analog_read: assert property (
        st_q == DCC_ST_READ && hit_q && idx_q == `DCC_IDX_PORTA
        |=> (hrdata_q[3:0] & $past(amask)) == 4'h0)
        else $error("analog pin read nonzero");

    a_wake_on: assert property (
        sleep && flag_q && chg_en_q |-> wake)
        else $error("wake missing");

    a_route_four: assert property (
        mode_q == DCC_M_FOUR |-> cmp2_inv_sel == (switch_q ? 2'h2 : 2'h1))
        else $error("second routing wrong");

    c_flag: cover property (!flag_q ##1 flag_q);
    c_outmode: cover property (mode_q == DCC_M_OUTPUT && port_a_oe[3]);
    c_wake: cover property ($rose(wake));
    c_soft_set: cover property (wr_now && idx_q == `DCC_IDX_PFLAG
                                && hwdata[`DCC_B_CHG]);
    c_mode_off: cover property (mode_q == DCC_M_OFF);

endmodule // dcc_top

//--- dv/dcc_analog_model.sv
module dcc_analog_model (
    // Clock
    input  wire logic            clk,
    // Routing chosen by the block
    input  wire logic            power_on,
    input  wire logic            ref_sel,
    input  wire logic [1:0]      sel1,
    input  wire logic [1:0]      sel2,
    input  wire logic [3:0]      ref_level,
    // Pin levels pins 3..0
    input  wire logic [3:0][7:0] ain,
    // Comparator results
    output logic                 res1,
    output logic                 res2
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] vp;

    // Reference or pin 2 on the plus side
    assign vp = ref_sel ? {ref_level, 4'h8} : ain[2];

    // Powered-off outputs wander, an unknown start wanders to one
    always @(posedge clk) begin
        res1 <= power_on ? (vp > ain[sel1]) : (res1 !== 1'b1);
        res2 <= power_on ? (vp > ain[sel2]) : (res2 !== 1'b1);
    end
endmodule // dcc_analog_model

//--- dv/dual_comparator_control_bench.sv
`include "dcc_cfg.svh"

module dual_comparator_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clk, reset, hsel, hwrite, sleep;
    logic [31:0]     haddr, hwdata;
    logic [1:0]      htrans;
    logic [4:0]      port_a_in;
    logic [3:0][7:0] ain;
    logic [7:0]      rd;
    wire logic       hreadyout, hresp, cmp1_raw, cmp2_raw, cmp_power_on;
    wire logic       vref_to_noninv, vref_enable, vref_pin_out;
    wire logic       vref_low_range, cpu_irq, wake;
    wire logic [31:0] hrdata;
    wire logic [1:0] cmp1_inv_sel, cmp2_inv_sel;
    wire logic [3:0] vref_level, port_a_analog;
    wire logic [4:0] port_a_out, port_a_oe;
    logic [3:0]      amask [8] = '{`DCC_AM_M0, `DCC_AM_M1, `DCC_AM_M2,
        `DCC_AM_M3, `DCC_AM_M4, `DCC_AM_M5, `DCC_AM_M6, `DCC_AM_M7};
    int              n_fail, comparisons;

    dcc_top u_dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .cmp1_raw, .cmp2_raw, .cmp_power_on, .cmp1_inv_sel,
        .cmp2_inv_sel, .vref_to_noninv, .vref_enable, .vref_pin_out,
        .vref_low_range, .vref_level, .port_a_in, .port_a_out, .port_a_oe,
        .port_a_analog, .sleep, .cpu_irq, .wake);

    dcc_analog_model u_model (.clk, .power_on(cmp_power_on),
        .ref_sel(vref_to_noninv), .sel1(cmp1_inv_sel), .sel2(cmp2_inv_sel),
        .ref_level(vref_level), .ain, .res1(cmp1_raw), .res2(cmp2_raw));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_reg(string w, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chk_pin(string w, logic [4:0] e, logic [4:0] g);
        chk_reg(w, {3'h0, e}, {3'h0, g});
    endtask

    // One single word transfer, waits on hready
    task automatic bus(logic wr, logic [7:0] idx, logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        do begin @(posedge clk); end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do begin @(posedge clk); end while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask

    task automatic rreg(string w, logic [7:0] idx, logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk_reg(w, e, rd);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial begin
        logic [3:0] m;
        logic [7:0] v, vr;
        logic [4:0] d, p;
        logic       e1, e2;
        void'($urandom(28));
        {reset, hsel, hwrite, sleep, htrans} = 6'h20;
        {haddr, hwdata, port_a_in, ain} = '0;
        repeat (16) @(posedge clk);
        chk_pin("power in reset", 5'h0, {4'h0, cmp_power_on});
        reset <= 1'b0;
        bus(1'b0, `DCC_IDX_CMPCTL, 8'h00);
        chk_reg("ctl reset", 8'h00, rd);
        rreg("dir reset", `DCC_IDX_PADIR, 8'h1f);
        rreg("flag reset", `DCC_IDX_PFLAG, 8'h00);
        rreg("unmapped", 8'h40, 8'h00);
        bus(1'b1, `DCC_IDX_VREF, 8'hff);
        rreg("vref", `DCC_IDX_VREF, `DCC_VREF_MASK);
        bus(1'b1, `DCC_IDX_CMPCTL, 8'hff);
        rreg("ctl ro", `DCC_IDX_CMPCTL, 8'h0f);
        $display("test reset_regs done");
        // Every mode and switch value; comparator change enable stays off
        for (int i = 0; i < 16; i++) begin
            m = i[3:0];
            d = 5'($urandom);
            v = 8'($urandom);
            p = 5'($urandom);
            port_a_in <= 5'($urandom);
            ain <= $urandom;
            bus(1'b1, `DCC_IDX_VREF, v);
            bus(1'b1, `DCC_IDX_PADIR, {3'h0, d});
            bus(1'b1, `DCC_IDX_PORTA, {3'h0, p});
            bus(1'b1, `DCC_IDX_CMPCTL, {4'h0, m});
            bus(1'b0, `DCC_IDX_PORTA, 8'h00);
            chk_reg("port", {3'h0, port_a_in & {1'b1, ~amask[m[2:0]]}}, rd);
            @(negedge clk);
            chk_pin("route", {m[2:0] != 3'd7, m[2:0] == 3'd2, 1'b0,
                (m[2:0] inside {3'd1, 3'd2} && m[3]) ? 2'd3 : 2'd0},
                {cmp_power_on, vref_to_noninv, 1'b0, cmp1_inv_sel});
            chk_pin("oe", ~d, port_a_oe);
            chk_pin("analog", {1'b0, amask[m[2:0]]}, {1'b0, port_a_analog});
            chk_pin("pout", (m[2:0] == 3'd6) ? {cmp2_raw, cmp1_raw, p[2:0]} : p,
                port_a_out);
            chk_reg("vref pins", v & `DCC_VREF_MASK, {vref_enable,
                vref_pin_out, vref_low_range, 1'b0, vref_level});
            if (m[2:0] == 3'd2)
                chk_pin("sel2", m[3] ? 5'd2 : 5'd1, {3'h0, cmp2_inv_sel});
            if (m[2:0] == 3'd6)
                chk_pin("mux", {cmp2_raw, cmp1_raw, 3'h0}, port_a_out & 5'h18);
            repeat (4) @(posedge clk);
            vr = {v[3:0], 4'h8};
            e1 = vr > ain[m[3] ? 3 : 0];
            e2 = vr > ain[m[3] ? 2 : 1];
            bus(1'b0, `DCC_IDX_CMPCTL, 8'h00);
            chk_reg("ctl", (m[2:0] == 3'd2) ? {e2, e1, 2'b0, m} : {2'b0, m},
                (m[2:0] == 3'd2) ? rd : rd & 8'h3f);
        end
        $display("test mode_sweep done");
        // Change flag, enables, sleep and wake
        ain <= 32'h10101010;
        bus(1'b1, `DCC_IDX_VREF, 8'h04);
        bus(1'b1, `DCC_IDX_CMPCTL, 8'h02);
        repeat (4) @(posedge clk);
        bus(1'b0, `DCC_IDX_CMPCTL, 8'h00);
        bus(1'b1, `DCC_IDX_PFLAG, 8'h00);
        rreg("flag clear", `DCC_IDX_PFLAG, 8'h00);
        bus(1'b1, `DCC_IDX_PENA, 8'h40);
        bus(1'b1, `DCC_IDX_INTCTL, 8'hc0);
        ain[0] <= 8'hf0;
        repeat (4) @(posedge clk);
        rreg("flag set", `DCC_IDX_PFLAG, 8'h40);
        sleep <= 1'b1;
        @(negedge clk);
        chk_pin("irq wake", 5'h3, {3'h0, cpu_irq, wake});
        bus(1'b1, `DCC_IDX_INTCTL, 8'h40);
        @(negedge clk);
        chk_pin("irq masked", 5'h0, {4'h0, cpu_irq});
        bus(1'b1, `DCC_IDX_PFLAG, 8'h00);
        rreg("flag persist", `DCC_IDX_PFLAG, 8'h40);
        rreg("ctl asleep", `DCC_IDX_CMPCTL, 8'h82);
        bus(1'b1, `DCC_IDX_PFLAG, 8'h00);
        rreg("flag end", `DCC_IDX_PFLAG, 8'h00);
        bus(1'b1, `DCC_IDX_PFLAG, 8'h40);
        rreg("flag soft", `DCC_IDX_PFLAG, 8'h40);
        $display("test change_flag done");
        end_sim();
    end
endmodule // dual_comparator_control_bench
